// ### src/oscdc_ctrl_regs.sv
// Operation
// - Bus address readable at bits 7:1, answered
// - Bus address comes from nonvolatile memory
// - Revision refetched after reset and commit
// - Power-down bit decides start after reset
// - Setting power-down disables PLL, resets calibration
// - Clearing power-down re-enables and recalibrates
// - Trigger rising edge starts calibration
// - Trigger bit self-clears when calibration completes
// - Autostart outranks trigger during reset handling
// - Autostart set: lock then enable output
// - Power-on, pin, software resets are equal
// - Autostart clear halts; later set launches
`timescale 1ns/100ps
module oscdc_ctrl_regs (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Device reset sources
   input wire logic external_reset_pin_n_i,
   input wire logic software_reset_bit_i,
   // Nonvolatile image
   input wire logic [6:0] nvm_device_bus_address_i,
   input wire logic [7:0] nvm_image_revision_id_i,
   input wire logic [7:0] nvm_device_control_i,
   input wire logic [9:0] nvm_crystal_margin_offset_i,
   input wire logic nvm_commit_done_i,
   // Synthesiser
   input wire logic cal_done_i,
   output oscdc_pkg::oscdc_pll_ctrl_t pll_ctrl_o,
   // Serial bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o
);

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [2:0] scl_s_q, sda_s_q, rst_s_q;
   logic scl_q, sda_q, pin_n_q, scl_p_q, sda_p_q;
   logic scl_d, sda_d, pin_n_d;

   // A level counts once the second and third stage agree
   always_comb begin
      scl_d = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_q;
      sda_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_q;
      pin_n_d = (rst_s_q[1] == rst_s_q[2]) ? rst_s_q[2] : pin_n_q;
   end

   // Pins idle high, so reset to one
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         rst_s_q <= 3'h7;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         pin_n_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[1:0], scl_i};
         sda_s_q <= {sda_s_q[1:0], sda_i};
         rst_s_q <= {rst_s_q[1:0], external_reset_pin_n_i};
         scl_q <= scl_d;
         sda_q <= sda_d;
         pin_n_q <= pin_n_d;
         scl_p_q <= scl_q;
         sda_p_q <= sda_q;
      end
   end

   logic scl_rise, scl_fall, bus_start, bus_stop;
   assign scl_rise = scl_q & ~scl_p_q;
   assign scl_fall = ~scl_q & scl_p_q;
   assign bus_start = scl_q & scl_p_q & ~sda_q & sda_p_q;
   assign bus_stop = scl_q & scl_p_q & sda_q & ~sda_p_q;

   // ************************************************************
   // Register state declarations
   // ************************************************************
   logic [6:0] addr_q, addr_d;
   logic [7:0] rev_q, rev_d, ctl_q, ctl_d;
   logic [9:0] xo_q, xo_d;
   oscdc_pkg::oscdc_seq_t seq_q, seq_d;
   oscdc_pkg::oscdc_pll_ctrl_t pll_q, pll_d;
   oscdc_pkg::oscdc_wr_t wr_q, wr_d;

   // Read multiplexer; unmapped offsets read zero
   function automatic logic [7:0] rd_byte(input logic [7:0] ofs);
      logic [7:0] v;
      v = 8'h00;
      unique case (ofs)
         oscdc_pkg::OFS_BUS_ADDRESS_VIEW: v = {addr_q, 1'b0};
         oscdc_pkg::OFS_IMAGE_REVISION: v = rev_q;
         oscdc_pkg::OFS_DEVICE_CONTROL: v = ctl_q;
         oscdc_pkg::OFS_XO_MARGIN_HIGH: v = {6'h00, xo_q[1:0]};
         oscdc_pkg::OFS_XO_MARGIN_LOW: v = xo_q[9:2];
         default: v = 8'h00;
      endcase
      return v;
   endfunction : rd_byte

   // ************************************************************
   // Serial bus slave
   // ************************************************************
   oscdc_pkg::oscdc_bus_t bst_q, bst_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] shf_q, shf_d, ptr_q, ptr_d;
   logic rw_q, rw_d, oe_q, oe_d;

   // Decisions other than the read NACK are taken on the falling clock so data is steady
   always_comb begin
      bst_d = bst_q;
      cnt_d = cnt_q;
      shf_d = shf_q;
      ptr_d = ptr_q;
      rw_d = rw_q;
      oe_d = oe_q;
      wr_d = '0;
      if (bus_start) begin
         bst_d = oscdc_pkg::BUS_ADDR;
         cnt_d = 4'h0;
         oe_d = 1'b1;
      end else if (bus_stop) begin
         bst_d = oscdc_pkg::BUS_IDLE;
         oe_d = 1'b1;
      end else if (scl_rise) begin
         unique case (bst_q)
            oscdc_pkg::BUS_ADDR, oscdc_pkg::BUS_PTR,
            oscdc_pkg::BUS_WDAT: begin
               shf_d = {shf_q[6:0], sda_q};
               cnt_d = cnt_q + 4'h1;
            end
            oscdc_pkg::BUS_RDAT: begin
               shf_d = {shf_q[6:0], 1'b0};
               cnt_d = cnt_q + 4'h1;
            end
            oscdc_pkg::BUS_RACK: begin
               // Not acknowledged: master is done reading
               if (sda_q) begin
                  bst_d = oscdc_pkg::BUS_IDLE;
               end
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         unique case (bst_q)
            oscdc_pkg::BUS_ADDR: begin
               if (cnt_q == oscdc_pkg::BITS_PER_BYTE) begin
                  if (shf_q[7:1] == addr_q) begin
                     bst_d = oscdc_pkg::BUS_AACK;
                     rw_d = shf_q[0];
                     oe_d = 1'b0;
                  end else begin
                     bst_d = oscdc_pkg::BUS_IDLE;
                  end
               end
            end
            oscdc_pkg::BUS_AACK: begin
               cnt_d = 4'h0;
               if (rw_q) begin
                  bst_d = oscdc_pkg::BUS_RDAT;
                  shf_d = rd_byte(ptr_q);
                  // First bit is the MSB: release for one, pull for zero
                  oe_d = rd_byte(ptr_q) > 8'h7F;
               end else begin
                  bst_d = oscdc_pkg::BUS_PTR;
                  oe_d = 1'b1;
               end
            end
            oscdc_pkg::BUS_PTR: begin
               if (cnt_q == oscdc_pkg::BITS_PER_BYTE) begin
                  bst_d = oscdc_pkg::BUS_PACK;
                  ptr_d = shf_q;
                  oe_d = 1'b0;
               end
            end
            oscdc_pkg::BUS_WDAT: begin
               if (cnt_q == oscdc_pkg::BITS_PER_BYTE) begin
                  bst_d = oscdc_pkg::BUS_DACK;
                  wr_d = '{valid: 1'b1, addr: ptr_q, data: shf_q};
                  ptr_d = ptr_q + 8'h01;
                  oe_d = 1'b0;
               end
            end
            oscdc_pkg::BUS_PACK, oscdc_pkg::BUS_DACK: begin
               bst_d = oscdc_pkg::BUS_WDAT;
               cnt_d = 4'h0;
               oe_d = 1'b1;
            end
            oscdc_pkg::BUS_RDAT: begin
               if (cnt_q == oscdc_pkg::BITS_PER_BYTE) begin
                  bst_d = oscdc_pkg::BUS_RACK;
                  ptr_d = ptr_q + 8'h01;
                  oe_d = 1'b1;
               end else begin
                  oe_d = shf_q[7];
               end
            end
            oscdc_pkg::BUS_RACK: begin
               bst_d = oscdc_pkg::BUS_RDAT;
               cnt_d = 4'h0;
               shf_d = rd_byte(ptr_q);
               oe_d = rd_byte(ptr_q) > 8'h7F;
            end
            default: begin
            end
         endcase
      end
   end

   // Bus state registers; pointer survives between transfers
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         bst_q <= oscdc_pkg::BUS_IDLE;
         cnt_q <= 4'h0;
         shf_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         oe_q <= 1'b1;
         wr_q <= '0;
         sda_o <= 1'b0;
      end else begin
         bst_q <= bst_d;
         cnt_q <= cnt_d;
         shf_q <= shf_d;
         ptr_q <= ptr_d;
         rw_q <= rw_d;
         oe_q <= oe_d;
         wr_q <= wr_d;
         sda_o <= 1'b0;
      end
   end

   // Open drain: only ever pulls low
   assign sda_oe_o = oe_q;

   // ************************************************************
   // Control registers and start-up sequencer
   // ************************************************************
   logic dev_rst, ctl_wr, trig_rise, pdn_new, auto_new;

   // Any reset source restarts the whole sequence
   assign dev_rst = ~pin_n_q | software_reset_bit_i;
   assign ctl_wr = wr_q.valid &
                   (wr_q.addr == oscdc_pkg::OFS_DEVICE_CONTROL);
   assign trig_rise = ctl_wr &
                      wr_q.data[oscdc_pkg::CTL_CALIBRATE_TRIGGER] &
                      ~ctl_q[oscdc_pkg::CTL_CALIBRATE_TRIGGER];
   assign pdn_new = ctl_d[oscdc_pkg::CTL_SYNTH_POWERDOWN];
   assign auto_new = ctl_d[oscdc_pkg::CTL_AUTO_LAUNCH];

   always_comb begin
      addr_d = addr_q;
      rev_d = rev_q;
      xo_d = xo_q;
      ctl_d = ctl_q;
      seq_d = seq_q;
      // Software write; trigger is set only by a rising write
      if (ctl_wr) begin
         ctl_d = (wr_q.data & oscdc_pkg::CTL_WRITE_MASK) |
                 (ctl_q & ~oscdc_pkg::CTL_WRITE_MASK);
         ctl_d[oscdc_pkg::CTL_CALIBRATE_TRIGGER] =
            ctl_q[oscdc_pkg::CTL_CALIBRATE_TRIGGER] | trig_rise;
      end
      // Commit refreshes the revision record
      if (nvm_commit_done_i) begin
         rev_d = nvm_image_revision_id_i;
      end
      unique case (seq_q)
         oscdc_pkg::SEQ_LOAD: begin
            // Image fetched here, never from a bus write
            addr_d = nvm_device_bus_address_i;
            rev_d = nvm_image_revision_id_i;
            xo_d = nvm_crystal_margin_offset_i;
            ctl_d = nvm_device_control_i & oscdc_pkg::CTL_WRITE_MASK;
            ctl_d[oscdc_pkg::CTL_CALIBRATE_TRIGGER] = 1'b0;
            seq_d = oscdc_pkg::SEQ_CONFIG;
         end
         oscdc_pkg::SEQ_CONFIG: begin
            // Trigger bit ignored here: power-down, then autostart decides
            if (pdn_new) begin
               seq_d = oscdc_pkg::SEQ_PDN;
            end else if (auto_new) begin
               seq_d = oscdc_pkg::SEQ_CAL;
            end else begin
               seq_d = oscdc_pkg::SEQ_HALT;
            end
         end
         oscdc_pkg::SEQ_HALT: begin
            if (pdn_new) begin
               seq_d = oscdc_pkg::SEQ_PDN;
            end else if (auto_new | trig_rise) begin
               seq_d = oscdc_pkg::SEQ_CAL;
            end
         end
         oscdc_pkg::SEQ_PDN: begin
            if (!pdn_new) begin
               seq_d = oscdc_pkg::SEQ_CAL;
            end
         end
         oscdc_pkg::SEQ_CAL: begin
            if (pdn_new) begin
               seq_d = oscdc_pkg::SEQ_PDN;
            end else if (cal_done_i) begin
               // A trigger in the same cycle keeps the bit set
               ctl_d[oscdc_pkg::CTL_CALIBRATE_TRIGGER] = trig_rise;
               seq_d = trig_rise ? oscdc_pkg::SEQ_CAL
                                 : oscdc_pkg::SEQ_RUN;
            end
         end
         oscdc_pkg::SEQ_RUN: begin
            if (pdn_new) begin
               seq_d = oscdc_pkg::SEQ_PDN;
            end else if (trig_rise) begin
               seq_d = oscdc_pkg::SEQ_CAL;
            end
         end
         default: begin
            seq_d = oscdc_pkg::SEQ_LOAD;
         end
      endcase
      if (dev_rst) begin
         seq_d = oscdc_pkg::SEQ_LOAD;
      end
   end

   // Synthesiser controls follow the next state, so they are flops
   always_comb begin
      pll_d.pll_enable = (seq_d == oscdc_pkg::SEQ_CAL) |
                         (seq_d == oscdc_pkg::SEQ_RUN);
      pll_d.cal_reset = ~pll_d.pll_enable;
      pll_d.cal_start = (seq_d == oscdc_pkg::SEQ_CAL) &
                        ((seq_q != oscdc_pkg::SEQ_CAL) |
                         (cal_done_i & trig_rise));
      pll_d.output_enable = seq_d == oscdc_pkg::SEQ_RUN;
   end

   // Register bank; outputs idle while the image loads
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         addr_q <= oscdc_pkg::BUS_ADDRESS_RESET;
         rev_q <= oscdc_pkg::IMAGE_REVISION_RESET;
         ctl_q <= oscdc_pkg::CTL_RESET;
         xo_q <= 10'h000;
         seq_q <= oscdc_pkg::SEQ_LOAD;
         pll_q <= '{cal_reset: 1'b1, default: 1'b0};
      end else begin
         addr_q <= addr_d;
         rev_q <= rev_d;
         ctl_q <= ctl_d;
         xo_q <= xo_d;
         seq_q <= seq_d;
         pll_q <= pll_d;
      end
   end

   assign pll_ctrl_o = pll_q;

endmodule : oscdc_ctrl_regs

// ### src/oscdc_pkg.sv
// ****************************************************************
// Oscillator device-control register group: shared definitions
// ****************************************************************
package oscdc_pkg;

   // ************************************************************
   // Register offsets on the serial bus
   // ************************************************************
   localparam logic [7:0] OFS_BUS_ADDRESS_VIEW = 8'h08;
   localparam logic [7:0] OFS_IMAGE_REVISION = 8'h09;
   localparam logic [7:0] OFS_DEVICE_CONTROL = 8'h0A;
   localparam logic [7:0] OFS_XO_MARGIN_HIGH = 8'h10;
   localparam logic [7:0] OFS_XO_MARGIN_LOW = 8'h11;

   // ************************************************************
   // Device control field positions
   // ************************************************************
   localparam int CTL_SYNTH_POWERDOWN = 6;
   localparam int CTL_SINGLE_ENDED = 5;
   localparam int CTL_RSVD_HI = 4;
   localparam int CTL_RSVD_LO = 2;
   localparam int CTL_CALIBRATE_TRIGGER = 1;
   localparam int CTL_AUTO_LAUNCH = 0;

   // ************************************************************
   // Reset values and control write mask
   // ************************************************************
   localparam logic [7:0] CTL_RESET = 8'h01;
   localparam logic [7:0] IMAGE_REVISION_RESET = 8'h00;
   localparam logic [6:0] BUS_ADDRESS_RESET = 7'h59;
   localparam logic [7:0] CTL_WRITE_MASK = 8'h7F;

   // ************************************************************
   // Bus byte layout
   // ************************************************************
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // Start-up sequencer states
   typedef enum logic [5:0] {
      SEQ_LOAD = 6'h01,
      SEQ_CONFIG = 6'h02,
      SEQ_HALT = 6'h04,
      SEQ_PDN = 6'h08,
      SEQ_CAL = 6'h10,
      SEQ_RUN = 6'h20
   } oscdc_seq_t;

   // Serial bus slave states
   typedef enum logic [8:0] {
      BUS_IDLE = 9'h001,
      BUS_ADDR = 9'h002,
      BUS_AACK = 9'h004,
      BUS_PTR = 9'h008,
      BUS_PACK = 9'h010,
      BUS_WDAT = 9'h020,
      BUS_DACK = 9'h040,
      BUS_RDAT = 9'h080,
      BUS_RACK = 9'h100
   } oscdc_bus_t;

   // Controls toward the synthesiser
   typedef struct packed {
      logic pll_enable;
      logic cal_reset;
      logic cal_start;
      logic output_enable;
   } oscdc_pll_ctrl_t;

   // One register write from the bus
   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [7:0] data;
   } oscdc_wr_t;

endpackage : oscdc_pkg

// ### testbench/oscdc_ctrl_regs_chk.sv
`timescale 1ns/100ps
// ********************************************************
// Port checker for the device-control register group
// ********************************************************
module oscdc_ctrl_regs_chk (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Device reset sources
   input wire logic external_reset_pin_n_i,
   input wire logic software_reset_bit_i,
   // Nonvolatile image
   input wire logic [6:0] nvm_device_bus_address_i,
   input wire logic [7:0] nvm_image_revision_id_i,
   input wire logic [7:0] nvm_device_control_i,
   input wire logic [9:0] nvm_crystal_margin_offset_i,
   input wire logic nvm_commit_done_i,
   // Synthesiser
   input wire logic cal_done_i,
   input wire oscdc_pkg::oscdc_pll_ctrl_t pll_ctrl_o,
   // Serial bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (reset_i);

   // Open-drain: only ever pulls low
   property p_sda_low;
      !sda_oe_o |-> sda_o == 1'b0;
   endproperty
   a_sda_low: assert property (p_sda_low)
      else $error("sda driven high");

   // Calibration start is a single pulse with the PLL on
   property p_start_pulse;
      pll_ctrl_o.cal_start |-> pll_ctrl_o.pll_enable ##1
         !pll_ctrl_o.cal_start;
   endproperty
   a_start_pulse: assert property (p_start_pulse)
      else $error("bad calibration start");

   // Calibration reset keeps PLL and output off
   property p_pdn_off;
      pll_ctrl_o.cal_reset |->
         !pll_ctrl_o.pll_enable && !pll_ctrl_o.output_enable;
   endproperty
   a_pdn_off: assert property (p_pdn_off)
      else $error("PLL on during calibration reset");

   // Output only comes up after calibration finished
   property p_out_cause;
      $rose(pll_ctrl_o.output_enable) |-> $past(cal_done_i);
   endproperty
   a_out_cause: assert property (p_out_cause)
      else $error("output enabled without calibration");

   // Autostart image launches calibration after power-on
   property p_auto_go;
      $fell(reset_i) && nvm_device_control_i[0] &&
         !nvm_device_control_i[6] |-> ##[0:4] pll_ctrl_o.cal_start;
   endproperty
   a_auto_go: assert property (p_auto_go)
      else $error("no calibration after reset");

   // Autostart clear: halt even if the trigger image bit is set
   property p_auto_hold;
      software_reset_bit_i && !nvm_device_control_i[0] |=>
         !pll_ctrl_o.cal_start [*8];
   endproperty
   a_auto_hold: assert property (p_auto_hold)
      else $error("calibration with autostart clear");

   // Software reset drops the output
   property p_sw_reset;
      software_reset_bit_i |-> ##2 !pll_ctrl_o.output_enable;
   endproperty
   a_sw_reset: assert property (p_sw_reset)
      else $error("output kept through software reset");

   // Pin reset drops the output and holds calibration
   property p_pin_hold;
      !external_reset_pin_n_i [*6] |=>
         !pll_ctrl_o.output_enable && !pll_ctrl_o.cal_start;
   endproperty
   a_pin_hold: assert property (p_pin_hold)
      else $error("device active during pin reset");

   // Pin release with autostart image launches calibration
   property p_pin_go;
      $rose(external_reset_pin_n_i) && nvm_device_control_i[0] &&
         !nvm_device_control_i[6] |-> ##[2:10] pll_ctrl_o.cal_start;
   endproperty
   a_pin_go: assert property (p_pin_go)
      else $error("no calibration after pin reset");
endmodule : oscdc_ctrl_regs_chk

bind oscdc_ctrl_regs oscdc_ctrl_regs_chk oscdc_ctrl_regs_chk_inst (
   .ref_clk_i, .reset_i, .external_reset_pin_n_i, .software_reset_bit_i,
   .nvm_device_bus_address_i, .nvm_image_revision_id_i,
   .nvm_device_control_i, .nvm_crystal_margin_offset_i,
   .nvm_commit_done_i, .cal_done_i, .pll_ctrl_o, .scl_i, .sda_i,
   .sda_o, .sda_oe_o
);

// ### testbench/oscdc_i2c_host.sv
`timescale 1ns/100ps
// ********************************************************
// Serial bus host model
// ********************************************************
module oscdc_i2c_host (
   // Clock
   input wire logic ref_clk_i,
   // Resolved data wire
   input wire logic sda_i,
   // Host pins, data open-drain (1 = released)
   output logic scl_o,
   output logic sda_o
);
   logic [6:0] dev_addr = 7'h59;

   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   // Eight clocks a phase: clear of the 4-clock minimum
   task automatic hp();
      repeat (8) @(posedge ref_clk_i);
      #1;
   endtask : hp

   // Data only moves while the clock is low
   task automatic bit_io(input logic b, output logic r);
      scl_o = 1'b0;
      hp();
      sda_o = b;
      hp();
      scl_o = 1'b1;
      hp();
      r = sda_i;
   endtask : bit_io

   task automatic start();
      scl_o = 1'b0;
      hp();
      sda_o = 1'b1;
      hp();
      scl_o = 1'b1;
      hp();
      sda_o = 1'b0;
      hp();
   endtask : start

   task automatic stop();
      scl_o = 1'b0;
      hp();
      sda_o = 1'b0;
      hp();
      scl_o = 1'b1;
      hp();
      sda_o = 1'b1;
      hp();
   endtask : stop

   // One byte MSB first, then the acknowledge bit
   task automatic xfer(input logic [7:0] wd, input logic nack,
                       output logic [7:0] rd, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(wd[i], r);
         rd[i] = r;
      end
      bit_io(nack, r);
      ack = !r;
   endtask : xfer

   // Callers keep single-ended select at 0 and skip margin regs
   task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] d);
      logic [7:0] rd;
      logic a;
      start();
      xfer({dev_addr, 1'b0}, 1'b1, rd, a);
      xfer(ofs, 1'b1, rd, a);
      xfer(d, 1'b1, rd, a);
      stop();
   endtask : wr_reg

   // Pointer write, repeated start, one byte read with NACK
   task automatic rd_reg(input logic [7:0] ofs, output logic [7:0] d);
      logic [7:0] rd;
      logic a;
      start();
      xfer({dev_addr, 1'b0}, 1'b1, rd, a);
      xfer(ofs, 1'b1, rd, a);
      start();
      xfer({dev_addr, 1'b1}, 1'b1, rd, a);
      xfer(8'hFF, 1'b1, d, a);
      stop();
   endtask : rd_reg

   task automatic probe(output logic ack);
      logic [7:0] rd;
      start();
      xfer({dev_addr, 1'b0}, 1'b1, rd, ack);
      stop();
   endtask : probe
endmodule : oscdc_i2c_host

// ### testbench/oscdc_ctrl_regs_tb_top.sv
`timescale 1ns/100ps
// ********************************************************
// Device-control register group testbench
// ********************************************************
module oscdc_ctrl_regs_tb_top;
   logic ref_clk_i;
   logic reset_i;
   logic pin_n;
   logic sw_rst;
   logic [6:0] nvm_adr;
   logic [7:0] nvm_rev;
   logic [7:0] nvm_ctl;
   logic commit;
   logic cal_done;
   logic scl;
   logic host_sda;
   logic sda_o;
   logic sda_oe_o;
   logic sda_w;
   logic [7:0] rd;
   logic ack;
   oscdc_pkg::oscdc_pll_ctrl_t pll;
   int err_count = 0;
   int n_tests = 0;
   int n_cal = 0;

   // Pulled-up wire: low if either side pulls
   assign sda_w = sda_oe_o & host_sda;

   oscdc_ctrl_regs oscdc_ctrl_regs_inst (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .external_reset_pin_n_i(pin_n), .software_reset_bit_i(sw_rst),
      .nvm_device_bus_address_i(nvm_adr),
      .nvm_image_revision_id_i(nvm_rev),
      .nvm_device_control_i(nvm_ctl),
      .nvm_crystal_margin_offset_i(10'h155),
      .nvm_commit_done_i(commit), .cal_done_i(cal_done),
      .pll_ctrl_o(pll), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe_o(sda_oe_o)
   );

   oscdc_i2c_host oscdc_i2c_host_inst (
      .ref_clk_i(ref_clk_i), .sda_i(sda_w),
      .scl_o(scl), .sda_o(host_sda)
   );

   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end

   // Count calibration launches
   always @(posedge ref_clk_i) begin
      if (pll.cal_start === 1'b1) n_cal++;
   end

   // Hang guard, well above the expected run
   initial begin
      repeat (60000) @(posedge ref_clk_i);
      err_count++;
      tally_and_finish();
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : tick

   task automatic rchk(input logic [7:0] ofs, input logic [7:0] exp);
      oscdc_i2c_host_inst.rd_reg(ofs, rd);
      chk(rd, exp);
   endtask : rchk

   task automatic pulse_done();
      cal_done = 1'b1;
      tick(1);
      cal_done = 1'b0;
   endtask : pulse_done

   task automatic tally_and_finish();
      if (err_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      reset_i = 1'b1;
      pin_n = 1'b1;
      sw_rst = 1'b0;
      nvm_adr = 7'h59;
      nvm_rev = 8'h3C;
      nvm_ctl = 8'h01;
      commit = 1'b0;
      cal_done = 1'b0;
      tick(12);
      reset_i = 1'b0;
      tick(8);
      chk(n_cal[7:0], 8'h01);
      pulse_done();
      chk({4'h0, pll}, 8'h09);
      rchk(8'h08, 8'hB2);
      rchk(8'h09, 8'h3C);
      rchk(8'h0A, 8'h01);
      rchk(8'h10, 8'h01);
      rchk(8'h11, 8'h55);
      // Read-only address view ignores a bus write
      oscdc_i2c_host_inst.wr_reg(8'h08, 8'hFF);
      rchk(8'h08, 8'hB2);
      nvm_rev = 8'hA5;
      commit = 1'b1;
      tick(1);
      commit = 1'b0;
      rchk(8'h09, 8'hA5);
      // Power-down, then release restarts calibration unasked
      oscdc_i2c_host_inst.wr_reg(8'h0A, 8'h41);
      chk({4'h0, pll}, 8'h04);
      oscdc_i2c_host_inst.wr_reg(8'h0A, 8'h01);
      chk(n_cal[7:0], 8'h02);
      pulse_done();
      // Manual trigger, read back set, then read back clear after calibration done
      oscdc_i2c_host_inst.wr_reg(8'h0A, 8'h03);
      chk(n_cal[7:0], 8'h03);
      rchk(8'h0A, 8'h03);
      pulse_done();
      rchk(8'h0A, 8'h01);
      // Foreign address is not acknowledged
      oscdc_i2c_host_inst.dev_addr = 7'h5A;
      oscdc_i2c_host_inst.probe(ack);
      chk({7'h00, ack}, 8'h00);
      // Software reset with autostart clear and trigger set in image
      nvm_ctl = 8'h02;
      nvm_adr = 7'h2C;
      nvm_rev = 8'h77;
      sw_rst = 1'b1;
      tick(1);
      sw_rst = 1'b0;
      tick(10);
      chk(n_cal[7:0], 8'h03);
      chk({7'h00, pll.output_enable}, 8'h00);
      oscdc_i2c_host_inst.dev_addr = 7'h2C;
      rchk(8'h08, 8'h58);
      rchk(8'h09, 8'h77);
      rchk(8'h0A, 8'h00);
      oscdc_i2c_host_inst.wr_reg(8'h0A, 8'h01);
      chk(n_cal[7:0], 8'h04);
      pulse_done();
      // Pin reset with autostart image launches again
      nvm_ctl = 8'h01;
      pin_n = 1'b0;
      tick(8);
      chk({7'h00, pll.output_enable}, 8'h00);
      pin_n = 1'b1;
      tick(14);
      chk(n_cal[7:0], 8'h05);
      tally_and_finish();
   end
endmodule : oscdc_ctrl_regs_tb_top
